// [hw/ptc_defs.svh]
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH
// Register byte offsets
`define PTC_OFF_CTRL      8'h00
`define PTC_OFF_CMD       8'h04
`define PTC_OFF_PERIOD    8'h08
`define PTC_OFF_CMP0      8'h0C
`define PTC_OFF_CMP1      8'h10
`define PTC_OFF_CMP2      8'h14
`define PTC_OFF_STATE     8'h18
`define PTC_OFF_MODIFY    8'h1C
`define PTC_OFF_COUNT     8'h20
`define PTC_OFF_MODE      8'h24
// Control field positions
`define PTC_CTRL_CLKSEL_LO 0
`define PTC_CTRL_PRE_BIT   3
`define PTC_CTRL_ISEL_LO   4
`define PTC_CTRL_CTM_BIT   6
`define PTC_CTRL_SSC_BIT   7
// Command bits (write one)
`define PTC_CMD_RUN_SET    0
`define PTC_CMD_RUN_CLR    1
`define PTC_CMD_COUNT      2
`define PTC_CMD_SHADOW     3
// Modify register: set bits 0..2, reset bits 8..10
`define PTC_MOD_RESET_LO   8
// Channel mode code for hysteresis-like control
`define PTC_MODE_HYST      4'h9
// Extra divider depth: divide by 256
`define PTC_EXTRA_DIV_LOG2 8
// Bus responses
`define PTC_RESP_OKAY      2'b00
`define PTC_RESP_SLVERR    2'b10
`endif

// [hw/ptc_pkg.sv]
`default_nettype none
package ptc_pkg;
  // Counter-input source selection
  typedef enum logic [1:0] {
    PTC_SRC_PRESCALE,
    PTC_SRC_SOFT,
    PTC_SRC_RISE,
    PTC_SRC_FALL
  } ptc_src_e;
  typedef logic [15:0] ptc_word_t;
endpackage
`default_nettype wire

// [hw/ptc_core.sv]
`include "ptc_defs.svh"
`default_nettype none
module ptc_core
  import ptc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_count_input,
  input  wire logic [2:0]  position_gate_input,
  output var  logic [2:0]  channel_state_bit,
  output var  logic [2:0]  rising_compare_event,
  output var  logic [2:0]  falling_compare_event,
  output var  logic        timer_run_bit
);

  // Control fields
  logic [2:0]  clock_divide_select;   // Prescaler code
  logic        extra_divider_enable;  // Adds the /256 stage
  logic [1:0]  count_input_select;    // Step source
  logic        center_align_select;   // Triangle counting
  logic        single_shot_enable;    // Stop after one period
  logic [11:0] channel_mode_code;     // Four bits per channel
  // Timer state
  ptc_word_t   counter;               // Count value
  logic        count_direction_flag;  // 1 = counting down
  logic [14:0] prescaler;             // Divider chain, held at zero while stopped
  ptc_word_t   period;                // Active period
  ptc_word_t   active_compare_reg [3];  // Feeds comparators
  ptc_word_t   shadow_compare_reg [3];  // Software preload
  logic        ext_prev;              // Last external level
  logic [2:0]  pos_q;                 // Sampled position inputs

  // Write-channel holding state
  logic        aw_held;               // Address accepted
  logic        w_held;                // Data accepted
  logic [7:0]  wr_addr;               // Latched write offset
  logic [31:0] wr_data;               // Latched write data
  logic [3:0]  wr_strb;               // Latched byte enables

  // Divide exponent: select code, plus eight with the /256 stage
  function automatic logic [3:0] div_exp(input logic [2:0] sel,
                                         input logic       pre);
    div_exp = {1'b0, sel} + (pre ? 4'(`PTC_EXTRA_DIV_LOG2) : 4'd0);
  endfunction

  // Timer clock enable: low prescaler bits all ones, last value before wrap to zero
  logic [3:0] div_idx;   // Divide exponent
  logic [14:0] div_mask; // Low bits that must be ones
  // Divide by one gives an empty mask: a step every clock
  assign div_idx  = div_exp(clock_divide_select,
                            extra_divider_enable);
  assign div_mask = 15'((16'h0001 << div_idx) - 16'h0001);

  ptc_src_e src;
  assign src = ptc_src_e'(count_input_select);

  // Write decode
  logic        wr_fire;      // Both halves present
  logic        wr_known;     // Address maps to a register
  logic [31:0] wr_eff;       // Data after byte enables
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_known = (wr_addr <= `PTC_OFF_MODE) && (wr_addr[1:0] == 2'b00);
  // Unwritten byte lanes of a register become zero
  assign wr_eff   = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                               {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  logic wr_cmd;              // Command register write
  logic wr_mod;              // Modify register write
  assign wr_cmd = wr_fire && (wr_addr == `PTC_OFF_CMD);
  assign wr_mod = wr_fire && (wr_addr == `PTC_OFF_MODIFY);

  // Step pulse from the selected source
  logic tick;
  logic soft_count_trigger;  // Software step request
  assign soft_count_trigger = wr_cmd && wr_eff[`PTC_CMD_COUNT];
  always_comb begin
    case (src)
      PTC_SRC_PRESCALE: tick = ((prescaler & div_mask) == div_mask);
      PTC_SRC_SOFT:     tick = soft_count_trigger;
      PTC_SRC_RISE:     tick = external_count_input && !ext_prev;
      PTC_SRC_FALL:     tick = !external_count_input && ext_prev;
      default:          tick = 1'b0;
    endcase
  end
  logic step;                // Timer clock event while running
  assign step = tick && timer_run_bit;

  // Match indications
  logic period_match;
  logic one_match;
  logic zero_match;
  assign period_match = (counter == period);
  assign one_match    = (counter == 16'h0001);
  assign zero_match   = (counter == 16'h0000);
  logic [2:0] channel_match;
  // A compare value above period+1 never matches: zero duty
  for (genvar c = 0; c < 3; c++) begin : g_cmp
    assign channel_match[c] = (counter == active_compare_reg[c]);
  end

  // Next counter value and direction
  ptc_word_t next_counter;
  logic      next_dir;
  always_comb begin
    next_dir = count_direction_flag;
    if (!center_align_select) begin
      next_dir     = 1'b0;
      next_counter = period_match ? 16'h0000 : counter + 16'h0001;
    end else begin
      // Move in the old direction, flip flag for the following step
      next_counter = count_direction_flag ? counter - 16'h0001
                                          : counter + 16'h0001;
      if (!count_direction_flag && period_match)
        next_dir = 1'b1;
      else if (count_direction_flag && one_match)
        next_dir = 1'b0;
    end
  end

  // Single-shot end of period
  logic shot_end;
  assign shot_end = single_shot_enable && step &&
                    (center_align_select
                     ? (count_direction_flag && one_match)
                     : period_match);

  // Counter, direction and prescaler
  // Prescaler restarts from zero at every start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter              <= 16'h0000;
      count_direction_flag <= 1'b0;
      prescaler            <= 15'h0000;
    end else begin
      prescaler <= timer_run_bit ? prescaler + 15'h0001 : 15'h0000;
      if (step) begin
        counter              <= next_counter;
        count_direction_flag <= next_dir;
      end else if (!timer_run_bit && wr_fire &&
                   wr_addr == `PTC_OFF_COUNT) begin
        // Count writes only land while stopped
        counter <= wr_eff[15:0];
      end
    end
  end

  // Run bit: commands, and hardware clear at end of single shot
  // Hardware stop wins over a same-cycle software start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_run_bit <= 1'b0;
    end else if (shot_end) begin
      timer_run_bit <= 1'b0;
    end else if (wr_cmd && wr_eff[`PTC_CMD_RUN_CLR]) begin
      timer_run_bit <= 1'b0;
    end else if (wr_cmd && wr_eff[`PTC_CMD_RUN_SET]) begin
      timer_run_bit <= 1'b1;  // Period must be nonzero first
    end
  end

  // Shadow transfer: software command only
  logic shadow_transfer_signal;
  assign shadow_transfer_signal = wr_cmd && wr_eff[`PTC_CMD_SHADOW];

  // Compare and shadow registers, control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        active_compare_reg[i] <= 16'h0000;
        shadow_compare_reg[i] <= 16'h0000;
      end
      period               <= 16'h0000;
      clock_divide_select  <= 3'h0;
      extra_divider_enable <= 1'b0;
      count_input_select   <= 2'h0;
      center_align_select  <= 1'b0;
      single_shot_enable   <= 1'b0;
      channel_mode_code    <= 12'h000;
      ext_prev             <= 1'b0;
      pos_q                <= 3'h0;
    end else begin
      ext_prev <= external_count_input;
      pos_q    <= position_gate_input;
      if (shadow_transfer_signal) begin
        for (int i = 0; i < 3; i++)
          active_compare_reg[i] <= shadow_compare_reg[i];
      end
      if (wr_fire) begin
        case (wr_addr)
          `PTC_OFF_CTRL: begin
            clock_divide_select  <= wr_eff[`PTC_CTRL_CLKSEL_LO +: 3];
            extra_divider_enable <= wr_eff[`PTC_CTRL_PRE_BIT];
            count_input_select   <= wr_eff[`PTC_CTRL_ISEL_LO +: 2];
            center_align_select  <= wr_eff[`PTC_CTRL_CTM_BIT];
            single_shot_enable   <= wr_eff[`PTC_CTRL_SSC_BIT];
          end
          `PTC_OFF_PERIOD: period <= wr_eff[15:0];
          `PTC_OFF_CMP0:   shadow_compare_reg[0] <= wr_eff[15:0];
          `PTC_OFF_CMP1:   shadow_compare_reg[1] <= wr_eff[15:0];
          `PTC_OFF_CMP2:   shadow_compare_reg[2] <= wr_eff[15:0];
          `PTC_OFF_MODE:   channel_mode_code <= wr_eff[11:0];
          default: ;
        endcase
      end
    end
  end

  // Per-channel switching rules
  logic [2:0] next_state;
  logic [2:0] hyst;
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      hyst[c] = (channel_mode_code[4*c +: 4] == `PTC_MODE_HYST);
      next_state[c] = channel_state_bit[c];
      if (step) begin
        if (!count_direction_flag && channel_match[c])
          next_state[c] = 1'b1;
        else if (count_direction_flag && channel_match[c])
          next_state[c] = 1'b0;
        else if (!count_direction_flag && zero_match)
          next_state[c] = 1'b0;
      end
      // Software set/reset override the compare rules; reset wins
      if (wr_mod && wr_eff[c])
        next_state[c] = 1'b1;
      if (wr_mod && wr_eff[`PTC_MOD_RESET_LO + c])
        next_state[c] = 1'b0;
      // A low gate in hysteresis mode overrides everything
      if (hyst[c] && !pos_q[c])
        next_state[c] = 1'b0;
    end
  end

  // State bits and compare events
  // Events show the counter value before the step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_state_bit     <= 3'h0;
      rising_compare_event  <= 3'h0;
      falling_compare_event <= 3'h0;
    end else begin
      channel_state_bit     <= next_state;
      rising_compare_event  <= step && !count_direction_flag ?
                               channel_match : 3'h0;
      falling_compare_event <= step && count_direction_flag ?
                               channel_match : 3'h0;
    end
  end

  // AXI write channels: accept each half, answer after both
  // A held half blocks its channel until the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PTC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr[7:0] |
                   {7'h00, |s_axi_awaddr[31:8]};  // High bits: unmapped
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  logic [7:0]  rd_off;
  logic [31:0] rd_word;
  logic        rd_known;
  assign rd_off = s_axi_araddr[7:0];
  always_comb begin
    rd_known = (s_axi_araddr[31:8] == 24'h000000) &&
               (rd_off <= `PTC_OFF_MODE) && (rd_off[1:0] == 2'b00);
    case (rd_off)
      `PTC_OFF_CTRL:   rd_word = {24'h000000, single_shot_enable,
                                  center_align_select, count_input_select,
                                  extra_divider_enable, clock_divide_select};
      `PTC_OFF_CMD:    rd_word = {30'h0000_0000, count_direction_flag,
                                  timer_run_bit};
      `PTC_OFF_PERIOD: rd_word = {16'h0000, period};
      `PTC_OFF_CMP0:   rd_word = {16'h0000, active_compare_reg[0]};
      `PTC_OFF_CMP1:   rd_word = {16'h0000, active_compare_reg[1]};
      `PTC_OFF_CMP2:   rd_word = {16'h0000, active_compare_reg[2]};
      `PTC_OFF_STATE:  rd_word = {29'h0000_0000, channel_state_bit};
      `PTC_OFF_COUNT:  rd_word = {16'h0000, counter};
      `PTC_OFF_MODE:   rd_word = {20'h0_0000, channel_mode_code};
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // AXI read channel: one-cycle ready pulse, data next cycle
  // Unmapped reads answer SLVERR with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PTC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_known ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_known ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [sim/ptc_core_assertions.sv]
`default_nettype none
// Port-level checker for the timer compare core
module ptc_core_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [2:0] position_gate_input,
  input wire logic [2:0] channel_state_bit,
  input wire logic [2:0] rising_compare_event,
  input wire logic [2:0] falling_compare_event,
  input wire logic       timer_run_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Reset drives every timer output low on the next edge
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> !timer_run_bit && (channel_state_bit | rising_compare_event
    | falling_compare_event) == 3'h0) else $error("outputs not cleared");
  // Read answer follows the address handshake by one clock
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Read and write answers stand until accepted
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  // Stopped, no write, gates open: state bits never move
  a_hold_stopped: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (!timer_run_bit && !s_axi_bvalid && &position_gate_input) [*3]
    |-> $stable(channel_state_bit)) else $error("state moved while stopped");
  // An event needs a running timer within the last two clocks
  a_step_run: assert property (@(posedge aclk) disable iff (!aresetn)
    (rising_compare_event | falling_compare_event) != 3'h0
    |-> $past(timer_run_bit) || $past(timer_run_bit, 2))
    else $error("event while stopped");
  for (genvar i = 0; i < 3; i++) begin : g_ch
    // Up-step match sets the bit when gate and run allow it
    a_up_sets: assert property (@(posedge aclk)
      disable iff (!aresetn)
      rising_compare_event[i] && $past(timer_run_bit)
      && $past(position_gate_input[i]) && $past(position_gate_input[i], 2)
      |-> channel_state_bit[i]) else $error("state not set on up match");
    // Down-step match clears the bit
    a_down_clears: assert property (@(posedge aclk)
      disable iff (!aresetn)
      falling_compare_event[i] && $past(timer_run_bit)
      |-> !channel_state_bit[i]) else $error("state not cleared");
    // Rising and falling events never coincide
    a_one_dir: assert property (@(posedge aclk) disable iff (!aresetn)
      !(rising_compare_event[i] && falling_compare_event[i]))
      else $error("both events at once");
    // Rising events are single-clock pulses
    a_event_pulse: assert property (@(posedge aclk)
      disable iff (!aresetn)
      rising_compare_event[i] |=> !rising_compare_event[i])
      else $error("event longer than a clock");
  end
endmodule
bind ptc_core ptc_core_chk u_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .position_gate_input, .channel_state_bit,
  .rising_compare_event, .falling_compare_event, .timer_run_bit);
`default_nettype wire

// [sim/ptc_gate_model.sv]
`default_nettype none
// Overcurrent comparator of the gate driver stage
module ptc_gate_model #(
  parameter bit SLOW = 1'h1  // Slow comparator adds one clock
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] trip_req,
  output var  logic [2:0] position_gate_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] stage1;  // First comparator stage
  logic [2:0] stage2;  // Extra delay for slow answers
  // Gate is high (allow) unless an overcurrent trip is commanded
  always_ff @(posedge aclk) begin
    stage1 <= aresetn ? ~trip_req : 3'h7;
    stage2 <= stage1;
  end
  assign position_gate_input = SLOW ? stage2 : stage1;
endmodule
`default_nettype wire

// [sim/ptc_core_tb.sv]
`include "ptc_defs.svh"
`default_nettype none
module ptc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk;
  logic        aresetn;
  logic [31:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [31:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        external_count_input;
  logic [2:0]  position_gate_input;
  logic [2:0]  channel_state_bit;
  logic [2:0]  rising_compare_event;
  logic [2:0]  falling_compare_event;
  logic        timer_run_bit;
  logic [2:0]  trip_req;      // Commanded overcurrent per channel
  logic [23:0] rise_n;        // Rising events, one byte per channel
  logic [23:0] fall_n;        // Falling events, one byte per channel
  int          run_n;         // Clocks seen with the timer running
  int          error_cnt;
  int          compares;
  int          cycles;
  int          d;             // Prescaler divisor under test
  ptc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input,
    .position_gate_input, .channel_state_bit, .rising_compare_event,
    .falling_compare_event, .timer_run_bit);
  ptc_gate_model #(.SLOW(1'h1)) u_gate (.aclk, .aresetn, .trip_req,
    .position_gate_input);
  // Clock at 125 MHz
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Register write: both halves offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = `PTC_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  // Register read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = `PTC_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  // Single-shot run: clear monitors, start, let it stop by itself
  task automatic shot();
    run_n = 0;
    rise_n = 24'h00_0000;
    fall_n = 24'h00_0000;
    wr(`PTC_OFF_CMD, 32'h0000_0001);
    repeat (20) @(posedge aclk);
  endtask
  // Watchdog and event monitor
  always @(posedge aclk) begin
    cycles++;
    run_n += int'(timer_run_bit);
    for (int i = 0; i < 3; i++) begin
      rise_n[8*i +: 8] += 8'(rising_compare_event[i]);
      fall_n[8*i +: 8] += 8'(falling_compare_event[i]);
    end
    if (cycles == 10000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    aresetn = 1'h0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    external_count_input = 1'h0;
    trip_req = 3'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    // Reset values, then the first unmapped word
    for (int a = 0; a <= 'h28; a += 4) begin
      rd(8'(a), 0, a == 'h28 ? `PTC_RESP_SLVERR : `PTC_RESP_OKAY);
    end
    wr(8'h28, 32'h0000_0001, `PTC_RESP_SLVERR);
    // Divisors 4..128 and 256, 512: 3.5 steps of run give 3
    wr(`PTC_OFF_PERIOD, 32'h0000_FFFF);
    for (int k = 2; k <= 9; k++) begin
      d = k <= 7 ? 1 << k : 256 << (k - 8);
      wr(`PTC_OFF_CTRL, k <= 7 ? 32'(k) : 32'(8 | (k - 8)));
      wr(`PTC_OFF_COUNT, 32'h0000_0000);
      wr(`PTC_OFF_CMD, 32'h0000_0001);
      repeat (d * 7 / 2 - 5) @(posedge aclk);
      wr(`PTC_OFF_CMD, 32'h0000_0002);
      rd(`PTC_OFF_COUNT, 3);
    end
    // Edge-aligned single shot, period 5, compares 2, 0, period+1
    wr(`PTC_OFF_CTRL, 32'h0000_0080);
    wr(`PTC_OFF_PERIOD, 5);
    wr(`PTC_OFF_COUNT, 0);
    wr(`PTC_OFF_CMP0, 2);
    wr(`PTC_OFF_CMP2, 6);
    rd(`PTC_OFF_CMP0, 0);
    wr(`PTC_OFF_CMD, 32'h0000_0008);
    rd(`PTC_OFF_CMP2, 6);
    shot();
    chk("run clocks", 6, run_n);
    chk("rise", 32'h0000_0101, 32'(rise_n));
    chk("state", 32'h0000_0003, 32'(channel_state_bit));
    // Center-aligned single shot, period 3, compares 2, 0, 5
    wr(`PTC_OFF_CTRL, 32'h0000_00C0);
    wr(`PTC_OFF_PERIOD, 3);
    wr(`PTC_OFF_CMP2, 5);
    wr(`PTC_OFF_CMD, 32'h0000_0008);
    shot();
    chk("run clocks", 8, run_n);
    chk("rise", 32'h0000_0101, 32'(rise_n));
    chk("fall", 32'h0000_0001, 32'(fall_n));
    rd(`PTC_OFF_STATE, 2);
    rd(`PTC_OFF_COUNT, 0);
    rd(`PTC_OFF_CMD, 0);
    // Counter mode: three soft steps, six rises, six falls
    wr(`PTC_OFF_CTRL, 32'h0000_0010);
    wr(`PTC_OFF_PERIOD, 32'h0000_FFFF);
    wr(`PTC_OFF_CMD, 32'h0000_0001);
    repeat (3) wr(`PTC_OFF_CMD, 32'h0000_0004);
    rd(`PTC_OFF_COUNT, 3);
    wr(`PTC_OFF_CTRL, 32'h0000_0020);
    for (int k = 0; k < 24; k++) begin
      if (k == 12) wr(`PTC_OFF_CTRL, 32'h0000_0030);
      repeat (3) @(posedge aclk);
      external_count_input <= ~external_count_input;
    end
    repeat (4) @(posedge aclk);
    rd(`PTC_OFF_COUNT, 15);
    wr(`PTC_OFF_CMD, 32'h0000_0002);
    // Hysteresis on channel 0, normal mode on channel 1
    wr(`PTC_OFF_MODE, 32'(`PTC_MODE_HYST));
    wr(`PTC_OFF_MODIFY, 32'h0000_0700);
    rd(`PTC_OFF_STATE, 0);
    wr(`PTC_OFF_MODIFY, 32'h0000_0003);
    rd(`PTC_OFF_STATE, 3);
    trip_req <= 3'h3;
    repeat (6) @(posedge aclk);
    rd(`PTC_OFF_STATE, 2);
    wr(`PTC_OFF_MODIFY, 32'h0000_0001);
    chk("state", 32'h0000_0002, 32'(channel_state_bit));
    trip_req <= 3'h0;
    repeat (6) @(posedge aclk);
    wr(`PTC_OFF_MODIFY, 32'h0000_0001);
    rd(`PTC_OFF_STATE, 3);
    wr(`PTC_OFF_MODIFY, 32'h0000_0700);
    chk("state", 32'h0000_0000, 32'(channel_state_bit));
    end_of_test();
  end
endmodule
`default_nettype wire
